// ---- hdl/cpl_pkg.sv ----
/*
  Constants of the configuration power and lock register bank: register
  indices, reset values, write masks, field positions and parallel modes.
  Assumes the configuration index register lives outside this bank.
*/
package cpl_pkg;

  // ***************************************************************
  // Register indices
  // ***************************************************************
  localparam int REG_COUNT = 3;
  localparam logic [7:0] IDX_VALID_FLAG = 8'h00;
  localparam logic [7:0] IDX_PORT_POWER_LOCK = 8'h01;
  localparam logic [7:0] IDX_SERIAL_POWER = 8'h02;
  localparam logic [7:0] IDX_LAST_CONFIG = 8'h2F;

  // ***************************************************************
  // Reset values and masks, entry 0 is index 00H
  // ***************************************************************
  localparam logic [7:0] RST_VALID_FLAG = 8'h28;
  localparam logic [7:0] RST_PORT_POWER_LOCK = 8'h9C;
  localparam logic [7:0] RST_SERIAL_POWER = 8'h88;
  localparam logic [7:0] WMASK_VALID_FLAG = 8'h80;
  localparam logic [7:0] WMASK_PORT_POWER_LOCK = 8'h8C;
  localparam logic [7:0] WMASK_SERIAL_POWER = 8'h88;
  localparam logic [7:0] STICKY_PORT_POWER_LOCK = 8'h80;
  localparam logic [7:0] STICKY_NONE = 8'h00;

  localparam logic [REG_COUNT-1:0][7:0] REG_RESET =
    {RST_SERIAL_POWER, RST_PORT_POWER_LOCK, RST_VALID_FLAG};
  localparam logic [REG_COUNT-1:0][7:0] REG_WMASK =
    {WMASK_SERIAL_POWER, WMASK_PORT_POWER_LOCK, WMASK_VALID_FLAG};
  localparam logic [REG_COUNT-1:0][7:0] REG_STICKY =
    {STICKY_NONE, STICKY_PORT_POWER_LOCK, STICKY_NONE};

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int BIT_VALID = 7;
  localparam int BIT_PAR_POWER = 2;
  localparam int BIT_PAR_PRINTER = 3;
  localparam int BIT_CFG_LOCK = 7;
  localparam int BIT_SER1_POWER = 3;
  localparam int BIT_SER2_POWER = 7;

  // ***************************************************************
  // Decoding and modes
  // ***************************************************************
  localparam int BASE_W = 10;
  localparam logic [BASE_W-1:0] DECODE_MIN_BASE = 10'h100;

  typedef enum logic [1:0] {
    PAR_SPP,
    PAR_EPP_SPP,
    PAR_ECP,
    PAR_ECP_EPP
  } cpl_par_mode_t;

endpackage

// ---- hdl/cpl_reg_cell.sv ----
/*
  One 8-bit configuration register with fixed read-only bits, writable
  bits and clear-only sticky bits.
  Assumes the write strobe is already qualified by index, state and lock.
*/
`timescale 1ns/100ps
`default_nettype none

module cpl_reg_cell #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK = 8'hFF,
  parameter logic [7:0] STICKY = 8'h00
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Write side
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  // Read side
  output logic [7:0] q
);

  logic [7:0] stored_reg;
  logic [7:0] stored_next;
  wire logic [7:0] merged;

  // Read-only bits never reach the flops, so writes cannot disturb them
  assign merged = (stored_reg & ~WMASK) | (wdata & WMASK);
  // A sticky bit can only fall; once low, a one written is dropped
  assign stored_next = wr_en ? (merged & (stored_reg | ~STICKY)) : stored_reg;
  assign q = (stored_reg & WMASK) | (RESET_VAL & ~WMASK);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stored_reg <= RESET_VAL;
    end else begin
      stored_reg <= stored_next;
    end
  end

endmodule

`default_nettype wire

// ---- hdl/cpl_config_regs.sv ----
/*
  Configuration registers 00H to 02H: validity flag, port power, parallel
  mode select and the configuration lock, with their outputs to the ports.
  Assumes the configuration index register, configuration state and host
  strobes come from logic on MCLK, one strobe pulse per host access.
*/
// Operation
// - Access only in config state at matching index
// - Validity resets 28H, bits 0-2 zero, 3 fixed
// - Validity bit 5 reads one, 4,6 zero
// - Valid flag clears at reset, drives nothing
// - Power-lock resets 9CH, fixed bits 0,1,4,5,6
// - Bit 2 high powers parallel port
// - Bit 3 high selects printer mode
// - Lock bit low blocks all 00-2F access
// - Cleared lock returns only by reset
// - Power-down keeps address decoding above 100h
// - Powered-down ports keep range checking
// - Serial power resets 88H, fixed zeros
// - Bit 3 high runs primary serial port
// - Bit 7 high runs secondary port, engine
// - Extended bits 1:0 pick parallel mode
`timescale 1ns/100ps
`default_nettype none

module cpl_config_regs
  import cpl_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // Configuration access
  input wire logic CFG_STATE,
  input wire logic [7:0] CFG_INDEX,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [7:0] CFG_WDATA,
  output logic [7:0] CFG_RDATA,
  output logic CFG_RDATA_VALID,
  output logic CFG_OWN_HIT,
  output logic CFG_ACCESS_EN,
  // Extended setup bits from the extended setup register
  input wire logic [1:0] EXT_MODE_SEL,
  // Host base addresses of the logical devices
  input wire logic [BASE_W-1:0] PAR_BASE,
  input wire logic [BASE_W-1:0] SER1_BASE,
  input wire logic [BASE_W-1:0] SER2_BASE,
  // Parallel port controls
  output logic PAR_POWER,
  output logic PAR_PRINTER_MODE,
  output logic [1:0] PAR_MODE,
  output logic PAR_DECODE_EN,
  // Serial port controls
  output logic SER1_POWER,
  output logic SER1_DECODE_EN,
  output logic SER2_POWER,
  output logic LINK_ENGINE_POWER,
  output logic SER2_DECODE_EN
);

  // ***************************************************************
  // Access decode
  // ***************************************************************
  wire logic [REG_COUNT-1:0][7:0] reg_q;
  wire logic [REG_COUNT-1:0] idx_hit;
  wire logic [REG_COUNT-1:0] wr_hit;
  wire logic cfg_unlocked;
  wire logic in_cfg_space;
  wire logic own_access;
  wire logic rd_take;
  wire logic [7:0] rd_mux;

  assign cfg_unlocked = reg_q[1][BIT_CFG_LOCK];
  assign in_cfg_space = (CFG_INDEX <= IDX_LAST_CONFIG);
  // Whole space 00-2F is closed to the host once the lock is low
  assign CFG_ACCESS_EN = CFG_STATE & cfg_unlocked & in_cfg_space;
  assign idx_hit[0] = (CFG_INDEX == IDX_VALID_FLAG);
  assign idx_hit[1] = (CFG_INDEX == IDX_PORT_POWER_LOCK);
  assign idx_hit[2] = (CFG_INDEX == IDX_SERIAL_POWER);
  assign own_access = CFG_ACCESS_EN & (|idx_hit);
  assign CFG_OWN_HIT = own_access;
  assign rd_take = CFG_RD & own_access;

  // ***************************************************************
  // Registers
  // ***************************************************************
  // Fixed bits come straight from the reset value in each cell, so the
  // 28H, 9CH and 88H patterns read back whatever software writes
  genvar gi;
  generate
    for (gi = 0; gi < REG_COUNT; gi++) begin : g_reg
      assign wr_hit[gi] = CFG_WR & CFG_ACCESS_EN & idx_hit[gi];
      cpl_reg_cell #(
        .RESET_VAL(REG_RESET[gi]),
        .WMASK(REG_WMASK[gi]),
        .STICKY(REG_STICKY[gi])
      ) u_cell (
        .clk(MCLK),
        .arst_n(ARST_N),
        .wr_en(wr_hit[gi]),
        .wdata(CFG_WDATA),
        .q(reg_q[gi])
      );
    end
  endgenerate

  // The valid flag is only ever moved by a host write and feeds nothing
  // but the read mux
  assign rd_mux = idx_hit[0] ? reg_q[0] :
                  idx_hit[1] ? reg_q[1] :
                  idx_hit[2] ? reg_q[2] : 8'h00;

  // ***************************************************************
  // Read data
  // ***************************************************************
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  assign rdata_next = rd_take ? rd_mux : rdata_reg;
  assign rvalid_next = rd_take;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign CFG_RDATA = rdata_reg;
  assign CFG_RDATA_VALID = rvalid_reg;

  // ***************************************************************
  // Parallel port mode
  // ***************************************************************
  cpl_par_mode_t par_mode;
  wire logic printer_mode;

  assign printer_mode = reg_q[1][BIT_PAR_PRINTER];
  // Printer mode forces plain SPP; the extended bits only count when low
  assign par_mode = printer_mode ? PAR_SPP : cpl_par_mode_t'(EXT_MODE_SEL);

  // ***************************************************************
  // Port outputs
  // ***************************************************************
  // Power bits come straight from the register flops; the mode also takes EXT_MODE_SEL
  assign PAR_POWER = reg_q[1][BIT_PAR_POWER];
  assign PAR_PRINTER_MODE = printer_mode;
  assign PAR_MODE = par_mode;
  assign SER1_POWER = reg_q[2][BIT_SER1_POWER];
  assign SER2_POWER = reg_q[2][BIT_SER2_POWER];
  assign LINK_ENGINE_POWER = reg_q[2][BIT_SER2_POWER];

  // Decode ignores power on purpose: a sleeping device keeps its range
  // claimed, and range checking rides on the same enable
  assign PAR_DECODE_EN = (PAR_BASE >= DECODE_MIN_BASE);
  assign SER1_DECODE_EN = (SER1_BASE >= DECODE_MIN_BASE);
  assign SER2_DECODE_EN = (SER2_BASE >= DECODE_MIN_BASE);

endmodule

`default_nettype wire

// ---- testbench/cpl_config_regs_monitor.sv ----
/* Port checker for the configuration register bank.
   Assumes it is bound to cpl_config_regs and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module cpl_config_regs_monitor (
  // Clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // Access
  input wire logic CFG_STATE,
  input wire logic [7:0] CFG_INDEX,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [7:0] CFG_WDATA,
  input wire logic [7:0] CFG_RDATA,
  input wire logic CFG_RDATA_VALID,
  input wire logic CFG_OWN_HIT,
  input wire logic CFG_ACCESS_EN,
  // Port controls
  input wire logic [1:0] EXT_MODE_SEL,
  input wire logic PAR_POWER,
  input wire logic PAR_PRINTER_MODE,
  input wire logic [1:0] PAR_MODE,
  input wire logic SER1_POWER,
  input wire logic SER2_POWER,
  input wire logic LINK_ENGINE_POWER
);
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!ARST_N);
  wire logic hw = CFG_WR && CFG_OWN_HIT;
  wire logic hr = CFG_RD && CFG_OWN_HIT;
  wire logic in_space = CFG_STATE && CFG_INDEX <= 8'h2F;
  logic lock_gone_reg;
  // Remembers an accepted zero written to the lock bit until reset
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lock_gone_reg <= 1'b0;
    end else if (hw && CFG_INDEX == 8'h01 && !CFG_WDATA[7]) begin
      lock_gone_reg <= 1'b1;
    end
  end
  property p_rd_ok; hr |=> CFG_RDATA_VALID; endproperty
  a_rd_ok: assert property (p_rd_ok) else $error("read lost");
  property p_rd_no; CFG_RD && !CFG_OWN_HIT |=> !CFG_RDATA_VALID; endproperty
  a_rd_no: assert property (p_rd_no) else $error("read leaked");
  property p_hit; CFG_OWN_HIT |-> CFG_STATE && CFG_ACCESS_EN && CFG_INDEX <= 8'h02; endproperty
  a_hit: assert property (p_hit) else $error("bad hit");
  property p_lock; lock_gone_reg |-> !CFG_ACCESS_EN; endproperty
  a_lock: assert property (p_lock) else $error("lock reopened");
  property p_pp;
    hw && CFG_INDEX == 8'h01 |=> {PAR_PRINTER_MODE, PAR_POWER} == $past(CFG_WDATA[3:2]);
  endproperty
  a_pp: assert property (p_pp) else $error("parallel bits");
  property p_ser;
    hw && CFG_INDEX == 8'h02 |=> SER1_POWER == $past(CFG_WDATA[3]) &&
      SER2_POWER == $past(CFG_WDATA[7]) && LINK_ENGINE_POWER == SER2_POWER;
  endproperty
  a_ser: assert property (p_ser) else $error("serial bits");
  property p_mode; PAR_MODE == (PAR_PRINTER_MODE ? 2'b00 : EXT_MODE_SEL); endproperty
  a_mode: assert property (p_mode) else $error("par mode");
  property p_fix; hr && CFG_INDEX == 8'h00 |=> CFG_RDATA[6:0] == 7'h28; endproperty
  a_fix: assert property (p_fix) else $error("fixed bits");
  c_rd: cover property (hr ##1 CFG_RDATA_VALID);
  c_lock: cover property (lock_gone_reg && in_space);
  c_ext: cover property (!PAR_PRINTER_MODE && PAR_MODE == 2'b11);
endmodule
bind cpl_config_regs cpl_config_regs_monitor u_mon (.*);
`default_nettype wire

// ---- testbench/cpl_host_model.sv ----
/* Host software model issuing configuration accesses.
   Assumes the bench calls acc and that strobes are synchronous to MCLK. */
`timescale 1ns/100ps
`default_nettype none
module cpl_host_model (
  // Clock and read return
  input wire logic MCLK,
  input wire logic [7:0] CFG_RDATA,
  input wire logic CFG_RDATA_VALID,
  // Access drive
  output logic CFG_STATE,
  output logic [7:0] CFG_INDEX,
  output logic CFG_WR,
  output logic CFG_RD,
  output logic [7:0] CFG_WDATA
);
  initial begin
    {CFG_STATE, CFG_INDEX, CFG_WR, CFG_RD, CFG_WDATA} = '0;
  end
  // One-cycle strobe, answer taken one cycle later; valid flag set only here
  task automatic acc(input logic st, input logic [7:0] ix, input logic w,
                     input logic [7:0] d, output logic [7:0] q, output logic ok);
    @(negedge MCLK);
    {CFG_STATE, CFG_INDEX, CFG_WR, CFG_RD, CFG_WDATA} = {st, ix, w, !w, d};
    @(negedge MCLK);
    {CFG_WR, CFG_RD, CFG_WDATA} = {2'b00, ~d};
    q = CFG_RDATA;
    ok = CFG_RDATA_VALID;
  endtask
endmodule
`default_nettype wire

// ---- testbench/config_power_lock_regs_tb.sv ----
/* Self-checking bench for the configuration register bank.
   Assumes the host model drives all access pins at the falling edge. */
`timescale 1ns/100ps
`default_nettype none
module config_power_lock_regs_tb;
  logic MCLK = 0, ARST_N = 0, st, wr, rd, rv, oh, ae, pp, pm, s1, s2, le, pd, d1, d2, ok;
  logic [7:0] ix, wd, rdat, q, d, lr;
  logic [1:0] ext = 0, mo;
  logic [9:0] pb = 0, b1 = 0, b2 = 0;
  logic [7:0] m [3];
  int fails = 0, n_tests = 0, i, e;
  always #50 MCLK = ~MCLK;
  cpl_host_model u_host (.MCLK(MCLK), .CFG_RDATA(rdat), .CFG_RDATA_VALID(rv), .CFG_STATE(st),
    .CFG_INDEX(ix), .CFG_WR(wr), .CFG_RD(rd), .CFG_WDATA(wd));
  cpl_config_regs u_dut (.MCLK(MCLK), .ARST_N(ARST_N), .CFG_STATE(st), .CFG_INDEX(ix),
    .CFG_WR(wr), .CFG_RD(rd), .CFG_WDATA(wd), .CFG_RDATA(rdat), .CFG_RDATA_VALID(rv),
    .CFG_OWN_HIT(oh), .CFG_ACCESS_EN(ae), .EXT_MODE_SEL(ext), .PAR_BASE(pb), .SER1_BASE(b1),
    .SER2_BASE(b2), .PAR_POWER(pp), .PAR_PRINTER_MODE(pm), .PAR_MODE(mo), .PAR_DECODE_EN(pd),
    .SER1_POWER(s1), .SER1_DECODE_EN(d1), .SER2_POWER(s2), .LINK_ENGINE_POWER(le),
    .SER2_DECODE_EN(d2));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] k;
    k = (a == 8'h00) ? 8'h80 : (a == 8'h01) ? 8'h8C : 8'h88;
    u_host.acc(1'b1, a, 1'b1, v, q, ok);
    if (m[1][7] && a < 8'h03) m[a] = (m[a] & ~k) | (v & k);
  endtask
  task automatic rd_reg(input logic s, input logic [7:0] a);
    u_host.acc(s, a, 1'b0, 8'h00, q, ok);
    chk(ok, s && m[1][7] && a < 8'h03);
    if (s && m[1][7] && a < 8'h03) lr = m[a];
    chk(q, lr);
  endtask
  task automatic chk_out();
    chk({pp, pm, s1, s2, le, mo, pd, d1, d2}, {m[1][2], m[1][3], m[2][3], m[2][7], m[2][7],
      m[1][3] ? 2'b00 : ext, pb >= 10'h100, b1 >= 10'h100, b2 >= 10'h100});
    chk({ae, oh}, {st && m[1][7] && ix <= 8'h2F, st && m[1][7] && ix < 8'h03});
  endtask
  task automatic do_reset();
    @(negedge MCLK);
    ARST_N = 0;
    m = '{8'h28, 8'h9C, 8'h88};
    lr = 8'h00;
    repeat (3) @(negedge MCLK);
    ARST_N = 1;
  endtask
  task automatic report_and_stop();
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    report_and_stop();
  end
  initial begin
    i = $urandom(32'hC56D);
    do_reset();
    for (i = 0; i < 3; i++) rd_reg(1'b1, i[7:0]);
    chk_out();
    repeat (30) begin
      i = $urandom % 3;
      d = 8'($urandom);
      if (i == 1) d[7] = 1'b1;
      {pb, b1, b2, ext} = $urandom;
      wr_reg(i[7:0], d);
      rd_reg(1'b1, i[7:0]);
      chk_out();
    end
    u_host.acc(1'b0, 8'h02, 1'b1, 8'h00, q, ok);
    rd_reg(1'b1, 8'h02);
    rd_reg(1'b0, 8'h00);
    chk_out();
    rd_reg(1'b1, 8'h03);
    chk_out();
    rd_reg(1'b1, 8'h30);
    chk_out();
    wr_reg(8'h01, 8'h80);
    for (e = 0; e < 4; e++) begin
      ext = e[1:0];
      @(negedge MCLK);
      chk_out();
    end
    wr_reg(8'h01, 8'h0C);
    wr_reg(8'h01, 8'h80);
    rd_reg(1'b1, 8'h01);
    chk_out();
    rd_reg(1'b1, 8'h00);
    do_reset();
    chk_out();
    rd_reg(1'b1, 8'h01);
    report_and_stop();
  end
endmodule
`default_nettype wire
